// [swuart_defines.svh]
// Constants of the single-wire UART datagram slave: framing codes,
// CRC, timing counts in bit times and clock cycles, FIFO shape.
// Assumes a 100 MHz system clock.
`ifndef SWUART_DEFINES_SVH
`define SWUART_DEFINES_SVH

`define CLK_HZ        100000000
`define DEF_BAUD      115200
// Bit time used for timeouts until a first datagram is accepted
`define DEF_BIT_TIME  16'((`CLK_HZ) / (`DEF_BAUD))

`define SYNC_BYTE     8'h05
`define SYNC_PRELOAD  8'ha0
`define REPLY_ADDR    8'hff
`define CRC_POLY      8'h07
`define CRC_INIT      8'h00

`define GLITCH_CYC    18'd16
`define TIMEOUT_BITS  7'd63
`define RECOVER_BITS  7'd12
`define RELEASE_BITS  8'd4
`define DELAY_STEP    8'd8

`define RESUME_IDX    4'd4
`define STOP_IDX      4'd9
`define WR_LAST       3'd7
`define RD_LAST       3'd3

`define WQ_DEPTH      16
`define WQ_W          39

`endif

// [swuart_pkg.sv]
// Types shared by the datagram slave.
// Assumes nothing of its surroundings.
package swuart_pkg;

  typedef enum logic [9:0] {
    ST_IDLE    = 10'h001,
    ST_SYNC    = 10'h002,
    ST_RXBIT   = 10'h004,
    ST_GAP     = 10'h008,
    ST_RECOVER = 10'h010,
    ST_PUSH    = 10'h020,
    ST_RDWAIT  = 10'h040,
    ST_DELAY   = 10'h080,
    ST_TX      = 10'h100,
    ST_RELEASE = 10'h200
  } link_state_t;

endpackage : swuart_pkg

// [line_sync.sv]
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes inputs asynchronous to sys_clk.
`timescale 1ns/100ps
`default_nettype none

module line_sync #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  input  wire logic         sys_clk,  // system clock
  input  wire logic         rstn,     // async reset, active low
  input  wire logic [W-1:0] async_in, // raw pins
  output logic      [W-1:0] filt      // filtered level
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_filt;

  // A bit changes only when stages two and three agree
  always_comb begin
    next_filt = (s2 & s3) | (filt & (s2 | s3));
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s1   <= INIT;
      s2   <= INIT;
      s3   <= INIT;
      filt <= INIT;
    end else begin
      s1   <= async_in;
      s2   <= s1;
      s3   <= s2;
      filt <= next_filt;
    end
  end

endmodule : line_sync
`default_nettype wire

// [wq_fifo.sv]
// Write-datagram FIFO with a registered output stage.
// Assumes one clock; in_ready is low while the store is full.
`timescale 1ns/100ps
`default_nettype none

module wq_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         sys_clk,   // system clock
  input  wire logic         rstn,      // async reset, active low
  input  wire logic         in_valid,  // write side valid
  output logic              in_ready,  // room for a word
  input  wire logic [W-1:0] in_data,   // word in
  output logic              out_valid, // output word held
  input  wire logic         out_ready, // drain accepts
  output logic      [W-1:0] out_data   // word out
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;
  logic [AW-1:0] next_wp;
  logic [AW-1:0] next_rp;
  logic [AW:0]   next_cnt;
  logic          next_ov;
  logic [W-1:0]  next_od;
  logic          do_push;
  logic          do_load;

  assign in_ready = (cnt != (AW+1)'(DEPTH));

  always_comb begin
    do_push  = in_valid && in_ready;
    do_load  = (cnt != '0) && (!out_valid || out_ready);
    next_wp  = do_push ? wp + 1'b1 : wp;
    next_rp  = do_load ? rp + 1'b1 : rp;
    next_ov  = out_valid;
    next_od  = out_data;
    next_cnt = cnt;
    if (do_load) begin
      next_ov = 1'b1;
      next_od = mem[rp];
    end else if (out_ready) begin
      next_ov = 1'b0;
    end
    if (do_push && !do_load) begin
      next_cnt = cnt + 1'b1;
    end else if (!do_push && do_load) begin
      next_cnt = cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wp        <= '0;
      rp        <= '0;
      cnt       <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      wp        <= next_wp;
      rp        <= next_rp;
      cnt       <= next_cnt;
      out_valid <= next_ov;
      out_data  <= next_od;
    end
  end

  // Storage needs no reset; words are only read after a push
  always_ff @(posedge sys_clk) begin
    if (do_push) begin
      mem[wp] <= in_data;
    end
  end

endmodule : wq_fifo
`default_nettype wire

// [swuart_slave.sv]
// Single-wire UART datagram slave: baud detection, datagram receive,
// write hand-off through a FIFO, read reply with delay and release.
// Assumes register map logic on the user ports, same clock.
`timescale 1ns/100ps
`default_nettype none
`include "swuart_defines.svh"

module swuart_slave
  import swuart_pkg::*;
(
  input  wire logic        sys_clk,             // 100 MHz clock
  input  wire logic        rstn,                // async reset
  input  wire logic        line_in,             // data pin level
  output logic             line_out,            // data pin drive value
  output logic             line_oe,             // data pin drive enable
  input  wire logic        node_addr_strap_lo,  // node address bit 0
  input  wire logic        node_addr_strap_hi,  // node address bit 1
  input  wire logic [3:0]  reply_delay_setting, // reply delay, x8 bits
  output logic             wr_valid,            // write word ready
  input  wire logic        wr_ready,            // write word taken
  output logic      [6:0]  wr_addr,             // write register
  output logic      [31:0] wr_data,             // write data
  output logic             rd_req,              // read request pulse
  output logic      [6:0]  rd_addr,             // read register
  input  wire logic        rd_valid,            // read data present
  input  wire logic [31:0] rd_data,             // read data
  output logic      [7:0]  datagram_count       // accepted writes
);

  ////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] b);
    logic [7:0] x;
    x = c;
    for (int i = 0; i < 8; i++) begin
      x = {x[6:0], 1'b0} ^ ((x[7] ^ b[i]) ? `CRC_POLY : 8'h00);
    end
    crc8 = x;
  endfunction : crc8

  function automatic logic [7:0] tx_byte(input logic [2:0]  n,
                                         input logic [6:0]  r,
                                         input logic [31:0] d,
                                         input logic [7:0]  c);
    case (n)
      3'd0:    tx_byte = `SYNC_BYTE;
      3'd1:    tx_byte = `REPLY_ADDR;
      3'd2:    tx_byte = {1'b0, r};
      3'd3:    tx_byte = d[31:24];
      3'd4:    tx_byte = d[23:16];
      3'd5:    tx_byte = d[15:8];
      3'd6:    tx_byte = d[7:0];
      default: tx_byte = c;
    endcase
  endfunction : tx_byte

  function automatic logic [22:0] bt_mul(input logic [15:0] bt,
                                         input logic [6:0]  k);
    bt_mul = {7'h00, bt} * {16'h0000, k};
  endfunction : bt_mul

  ////////////////////////////////////////////////////////////////////
  logic [2:0]  pins_f;
  logic        line_f;
  logic [7:0]  node;

  line_sync #(.W(3), .INIT(3'h1)) u_sync (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .async_in ({node_addr_strap_hi, node_addr_strap_lo, line_in}),
    .filt     (pins_f)
  );

  assign line_f = pins_f[0];
  assign node   = {6'h00, pins_f[2:1]};

  ////////////////////////////////////////////////////////////////////
  link_state_t state, next_state;
  logic [17:0] cnt, next_cnt;
  logic [22:0] since, next_since;
  logic [15:0] bit_time, next_bit_time;
  logic [15:0] good_bt, next_good_bt;
  logic [3:0]  idx, next_idx;
  logic [7:0]  shreg, next_shreg;
  logic [7:0]  txb, next_txb;
  logic [2:0]  byte_num, next_byte_num;
  logic [7:0]  crc, next_crc;
  logic [7:0]  dg_addr, next_dg_addr;
  logic [7:0]  dg_reg, next_dg_reg;
  logic [31:0] dg_data, next_dg_data;
  logic        fall_n, next_fall_n;
  logic [7:0]  dly, next_dly;
  logic        line_q;
  logic        next_line_out, next_line_oe;
  logic        next_rd_req;
  logic [6:0]  next_rd_addr;
  logic [7:0]  next_count;

  logic        fall, rise, bt_end, half, is_last, crc_ok;
  logic [17:0] cnt_p1;
  logic [3:0]  dly_sel;
  logic [7:0]  delay_bits;
  logic        push_valid, push_ready, push_fire;

  assign fall    = line_q & ~line_f;
  assign rise    = ~line_q & line_f;
  assign cnt_p1  = cnt + 18'd1;
  assign bt_end  = (cnt_p1 == {2'b00, bit_time});
  assign half    = (cnt == {3'b000, bit_time[15:1]});
  assign is_last = dg_reg[7] ? (byte_num == `WR_LAST)
                             : (byte_num == `RD_LAST);
  assign crc_ok  = (shreg == crc);
  assign dly_sel = (reply_delay_setting == 4'h0) ? 4'h1
                                                 : reply_delay_setting;
  assign delay_bits = {4'h0, dly_sel} * `DELAY_STEP;
  assign push_valid = (state == ST_PUSH);
  assign push_fire  = push_valid && push_ready;

  wq_fifo #(.W(`WQ_W), .DEPTH(`WQ_DEPTH)) u_fifo (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   ({dg_reg[6:0], dg_data}),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  ({wr_addr, wr_data})
  );

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [7:0] b;
    b             = 8'h00;
    next_state    = state;
    next_cnt      = bt_end ? 18'd0 : cnt_p1;
    next_since    = (since == '1) ? since : since + 23'd1;
    next_bit_time = bit_time;
    next_good_bt  = good_bt;
    next_idx      = idx;
    next_shreg    = shreg;
    next_txb      = txb;
    next_byte_num = byte_num;
    next_crc      = crc;
    next_dg_addr  = dg_addr;
    next_dg_reg   = dg_reg;
    next_dg_data  = dg_data;
    next_fall_n   = fall_n;
    next_dly      = dly;
    next_line_out = line_out;
    next_line_oe  = line_oe;
    next_rd_req   = 1'b0;
    next_rd_addr  = rd_addr;
    next_count    = datagram_count;
    unique case (state)
      ST_IDLE: begin
        if (fall) begin
          next_state  = ST_SYNC;
          next_cnt    = 18'd0;
          next_since  = 23'd0;
          next_fall_n = 1'b0;
        end
      end
      ST_SYNC: begin
        next_cnt = cnt_p1;
        if (rise && cnt < `GLITCH_CYC) begin
          next_state = ST_RECOVER;
          next_since = 23'd0;
        end else if (cnt == '1) begin
          next_state = ST_RECOVER;
          next_since = 23'd0;
        end else if (fall && fall_n) begin
          next_bit_time = cnt_p1[17:2];
          next_state    = ST_RXBIT;
          next_cnt      = 18'd0;
          next_idx      = `RESUME_IDX;
          next_shreg    = `SYNC_PRELOAD;
          next_byte_num = 3'd0;
        end else if (fall) begin
          next_fall_n = 1'b1;
        end
      end
      ST_RXBIT: begin
        if (bt_end) begin
          next_idx = idx + 4'd1;
        end
        if (half) begin
          if (idx == 4'd0) begin
            if (line_f) begin
              next_state = ST_RECOVER;
              next_since = 23'd0;
            end
          end else if (idx != `STOP_IDX) begin
            next_shreg = {line_f, shreg[7:1]};
          end else if (!line_f) begin
            next_state = ST_RECOVER;
            next_since = 23'd0;
          end else begin
            next_crc = crc8((byte_num == 3'd0) ? `CRC_INIT : crc,
                            shreg);
            next_byte_num = byte_num + 3'd1;
            next_state    = ST_GAP;
            if (byte_num == 3'd1) begin
              next_dg_addr = shreg;
            end else if (byte_num == 3'd2) begin
              next_dg_reg = shreg;
            end else if (!is_last) begin
              next_dg_data = {dg_data[23:0], shreg};
            end
            if (is_last) begin
              next_since = 23'd0;
              if (!crc_ok) begin
                next_state = ST_RECOVER;
              end else if (dg_addr != node) begin
                next_state = ST_IDLE;
              end else begin
                next_good_bt = bit_time;
                if (dg_reg[7]) begin
                  next_state = ST_PUSH;
                end else begin
                  next_state   = ST_RDWAIT;
                  next_rd_req  = 1'b1;
                  next_rd_addr = dg_reg[6:0];
                end
              end
            end
          end
        end
      end
      ST_GAP: begin
        if (fall) begin
          next_state = ST_RXBIT;
          next_cnt   = 18'd0;
          next_idx   = 4'd0;
          next_since = 23'd0;
        end else if (since > bt_mul(good_bt, `TIMEOUT_BITS)) begin
          next_state = ST_RECOVER;
          next_since = 23'd0;
        end
      end
      ST_RECOVER: begin
        next_since = line_f ? since + 23'd1 : 23'd0;
        if (since >= bt_mul(good_bt, `RECOVER_BITS)) begin
          next_state = ST_IDLE;
        end
      end
      ST_PUSH: begin
        if (push_ready) begin
          next_count = datagram_count + 8'd1;
          next_state = ST_IDLE;
        end
      end
      ST_RDWAIT: begin
        if (rd_valid) begin
          next_dg_data = rd_data;
          next_state   = ST_DELAY;
          next_cnt     = 18'd0;
          next_dly     = 8'd0;
        end
      end
      ST_DELAY: begin
        if (bt_end) begin
          next_dly = dly + 8'd1;
          if (dly == delay_bits - 8'd1) begin
            b             = tx_byte(3'd0, dg_reg[6:0], dg_data, crc);
            next_state    = ST_TX;
            next_byte_num = 3'd0;
            next_txb      = b;
            next_crc      = crc8(`CRC_INIT, b);
            next_idx      = 4'd0;
            next_line_out = 1'b0;
            next_line_oe  = 1'b1;
          end
        end
      end
      ST_TX: begin
        if (bt_end) begin
          if (idx == `STOP_IDX) begin
            if (byte_num == `WR_LAST) begin
              next_state = ST_RELEASE;
              next_dly   = 8'd0;
            end else begin
              b = tx_byte(byte_num + 3'd1, dg_reg[6:0], dg_data, crc);
              next_byte_num = byte_num + 3'd1;
              next_txb      = b;
              next_crc      = crc8(crc, b);
              next_idx      = 4'd0;
              next_line_out = 1'b0;
            end
          end else begin
            next_idx      = idx + 4'd1;
            next_line_out = (idx == 4'd8) ? 1'b1 : txb[idx[2:0]];
          end
        end
      end
      ST_RELEASE: begin
        if (bt_end) begin
          next_dly = dly + 8'd1;
          if (dly == `RELEASE_BITS - 8'd1) begin
            next_line_oe = 1'b0;
            next_state   = ST_IDLE;
          end
        end
      end
      default: begin
        next_state   = ST_IDLE;
        next_line_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state          <= ST_IDLE;
      cnt            <= 18'd0;
      since          <= 23'd0;
      bit_time       <= `DEF_BIT_TIME;
      good_bt        <= `DEF_BIT_TIME;
      idx            <= 4'd0;
      shreg          <= 8'h00;
      txb            <= 8'h00;
      byte_num       <= 3'd0;
      crc            <= `CRC_INIT;
      dg_addr        <= 8'h00;
      dg_reg         <= 8'h00;
      dg_data        <= 32'h0000_0000;
      fall_n         <= 1'b0;
      dly            <= 8'h00;
      line_q         <= 1'b1;
      line_out       <= 1'b1;
      line_oe        <= 1'b0;
      rd_req         <= 1'b0;
      rd_addr        <= 7'h00;
      datagram_count <= 8'h00;
    end else begin
      state          <= next_state;
      cnt            <= next_cnt;
      since          <= next_since;
      bit_time       <= next_bit_time;
      good_bt        <= next_good_bt;
      idx            <= next_idx;
      shreg          <= next_shreg;
      txb            <= next_txb;
      byte_num       <= next_byte_num;
      crc            <= next_crc;
      dg_addr        <= next_dg_addr;
      dg_reg         <= next_dg_reg;
      dg_data        <= next_dg_data;
      fall_n         <= next_fall_n;
      dly            <= next_dly;
      line_q         <= line_f;
      line_out       <= next_line_out;
      line_oe        <= next_line_oe;
      rd_req         <= next_rd_req;
      rd_addr        <= next_rd_addr;
      datagram_count <= next_count;
    end
  end

  ////////////////////////////////////////////////////////////////////
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence rel_enter_s;
    state == ST_TX ##1 state == ST_RELEASE;
  endsequence

  count_step_a: assert property (push_fire |=>
    datagram_count == $past(datagram_count) + 8'd1)
    else $error("write did not bump counter");
  count_read_a: assert property (rd_req |->
    datagram_count == $past(datagram_count, 2))
    else $error("read changed counter");
  glitch_rec_a: assert property (
    state == ST_SYNC && rise && cnt < `GLITCH_CYC |=> state == ST_RECOVER)
    else $error("glitch not recovered");
  crc_bad_a: assert property (
    state == ST_RXBIT && half && idx == `STOP_IDX && line_f && is_last
    && !crc_ok |=> state == ST_RECOVER)
    else $error("bad crc accepted");
  node_match_a: assert property (push_valid |-> dg_addr == node)
    else $error("foreign node write");
  frame_bits_a: assert property (
    state == ST_TX && idx == 4'd0 |-> !line_out && line_oe)
    else $error("start bit not low");
  reply_addr_a: assert property (
    state == ST_TX && byte_num == 3'd1 |-> txb == `REPLY_ADDR)
    else $error("reply address wrong");
  gap_timeout_a: assert property (
    state == ST_GAP && !fall && since > bt_mul(good_bt, `TIMEOUT_BITS)
    |=> state == ST_RECOVER)
    else $error("gap timeout missed");
  release_on_a: assert property (rel_enter_s |-> line_oe && line_out)
    else $error("driver dropped early");
  release_end_a: assert property ($fell(line_oe) |->
    $past(state) == ST_RELEASE && $past(dly) == `RELEASE_BITS - 8'd1)
    else $error("driver off at wrong time");
  sync_meas_a: assert property (
    state == ST_SYNC && fall && fall_n && cnt < 18'h3ffff
    |=> state == ST_RXBIT && idx == `RESUME_IDX)
    else $error("sync measurement lost");

endmodule : swuart_slave
`default_nettype wire

// [host_model.sv]
// Host UART model on the shared data line, 32 cycles per bit.
// Assumes the bench resolves the wire from tx and the slave's drive.
`timescale 1ns/100ps
`default_nettype none

module host_model (
  input  wire logic sys_clk, // system clock
  input  wire logic line,    // resolved wire level
  output var logic  tx       // host drive, high when idle
);
  // Fixed rate well inside the legal baud window
  int t = 32;

  initial tx = 1'b1;

  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      tx <= f[i];
      repeat (t) @(posedge sys_clk);
    end
  endtask : send_byte

  // Short low pulse on an idle line, then idle again
  task automatic glitch();
    tx <= 1'b0;
    repeat (8) @(posedge sys_clk);
    tx <= 1'b1;
  endtask : glitch

  task automatic recv_byte(output logic [7:0] b, output logic ok);
    while (line !== 1'b0) @(posedge sys_clk);
    repeat (t / 2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (t) @(posedge sys_clk);
      b[i] = line;
    end
    repeat (t) @(posedge sys_clk);
    ok = (line === 1'b1);
  endtask : recv_byte
endmodule : host_model

`default_nettype wire

// [tb.sv]
// Bench of the datagram slave: writes, refusals, recovery, two reads.
// Assumes host_model at 32 cycles per bit and a 100 MHz clock.
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic        sys_clk, rstn, line, tx, wr_ready, rd_valid;
  logic        line_out, line_oe, wr_valid, rd_req, ok;
  logic [1:0]  strap;
  logic [3:0]  dly;
  logic [6:0]  wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data, d;
  logic [7:0]  datagram_count, exp_cnt, rg, rb;
  logic [7:0]  e[8];
  logic [2:0]  v;
  logic [38:0] q[$];
  int          err_count, n_compared, cyc, rq_cyc;
  int          seed = 32'hcc654047;

  assign line = line_oe ? line_out : tx;

  swuart_slave uut (.sys_clk, .rstn, .line_in(line), .line_out, .line_oe,
    .node_addr_strap_lo(strap[0]), .node_addr_strap_hi(strap[1]),
    .reply_delay_setting(dly), .wr_valid, .wr_ready, .wr_addr, .wr_data,
    .rd_req, .rd_addr, .rd_valid, .rd_data, .datagram_count);
  host_model host (.sys_clk, .line, .tx);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    wr_ready <= 1'($random(seed));
    cyc <= cyc + 1;
    if (wr_valid === 1'b1 && wr_ready === 1'b1)
      q.push_back({wr_addr, wr_data});
    if (rd_req === 1'b1) rq_cyc = cyc;
    if (cyc == 70000) begin
      err_count++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (err_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %0t %h %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [7:0] crc(input logic [7:0] b[8], input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < n; i++)
      for (int j = 0; j < 8; j++)
        c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i][j]) ? 8'h07 : 8'h00);
    return c;
  endfunction : crc

  // Cycles from the read strobe to the reply's start bit at 32 per bit
  function automatic int reply_wait(input logic [3:0] s);
    return 8 * 32 * ((s == 4'h0) ? 1 : int'(s));
  endfunction : reply_wait

  task automatic send_dg(input logic [7:0] nd, input logic [7:0] r,
                         input logic [31:0] x, input bit bad);
    logic [7:0] b[8];
    int         n;
    n = r[7] ? 8 : 4;
    b = '{8'h05, nd, r, x[31:24], x[23:16], x[15:8], x[7:0], 8'h00};
    b[n-1] = crc(b, n - 1) ^ {7'h00, bad};
    for (int i = 0; i < n; i++) host.send_byte(b[i]);
  endtask : send_dg

  task automatic wr_check(input logic [7:0] r, input logic [31:0] x,
                          input bit acc);
    for (int k = 0; k < 100 && (q.size() == 0 || !acc); k++)
      @(posedge sys_clk);
    chk(q.size(), acc);
    if (acc && q.size() > 0) begin
      exp_cnt++;
      chk(q.pop_front(), {r[6:0], x});
    end
    chk(datagram_count, exp_cnt);
  endtask : wr_check

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, strap, exp_cnt, err_count, n_compared} = '0;
    {rd_valid, dly, rd_data} = {1'b1, 4'h2, 32'h0};
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    // Own node and a foreign node for every strap setting
    for (int i = 0; i < 8; i++) begin
      v = 3'(i);
      strap <= v[2:1];
      rg = (i == 2) ? 8'hff : 8'h80 | 8'($random(seed));
      d = $random(seed);
      repeat (20) @(posedge sys_clk);
      send_dg({6'h00, v[2:1] ^ {1'b0, v[0]}}, rg, d, 1'b0);
      wr_check(rg, d, !v[0]);
    end
    // Bad CRC, then a glitch: next datagram is lost until 12 idle bits
    for (int k = 0; k < 2; k++) begin
      if (k == 0) send_dg({6'h00, strap}, 8'h90, d, 1'b1);
      else host.glitch();
      wr_check(8'h90, d, 1'b0);
      send_dg({6'h00, strap}, 8'h91, d, 1'b0);
      wr_check(8'h91, d, 1'b0);
      repeat (14 * 32) @(posedge sys_clk);
      send_dg({6'h00, strap}, 8'h92, d, 1'b0);
      wr_check(8'h92, d, 1'b1);
    end
    // Cut datagram: the gap timeout, then recovery, must free the receiver
    host.send_byte(8'h05);
    host.send_byte({6'h00, strap});
    host.send_byte(8'h93);
    repeat (80 * 32) @(posedge sys_clk);
    send_dg({6'h00, strap}, 8'h94, d, 1'b0);
    wr_check(8'h94, d, 1'b1);
    // Reads with the default and a doubled reply delay
    for (int p = 0; p < 2; p++) begin
      dly     <= 4'(2 * p);
      rd_data <= $random(seed);
      rg = 8'($random(seed)) & 8'h7f;
      send_dg({6'h00, strap}, rg, 32'h0, 1'b0);
      e = '{8'h05, 8'hff, rg, rd_data[31:24], rd_data[23:16], rd_data[15:8],
            rd_data[7:0], 8'h00};
      e[7] = crc(e, 7);
      while (line !== 1'b0) @(posedge sys_clk);
      chk((cyc - rq_cyc - reply_wait(dly)) inside {[-22:18]}, 1'b1);
      chk(rd_addr, rg[6:0]);
      for (int i = 0; i < 8; i++) begin
        host.recv_byte(rb, ok);
        chk({ok, rb}, {1'b1, e[i]});
      end
      repeat (96) @(posedge sys_clk);
      chk(line_oe, 1'b1);
      repeat (72) @(posedge sys_clk);
      chk(line_oe, 1'b0);
      chk(datagram_count, exp_cnt);
    end
    end_of_test();
  end
endmodule : tb

`default_nettype wire
